// file: src/crspc_core_reset.v
// reset, wake-up state and program counter vectoring for the core
// Contract
// - program and data memory have separate buses for concurrent access.
// - program counter is 21 bits, addressing 2 megabytes.
// - reads above implemented flash return zeros, a no_operation.
// - flash size is a parameter of 16, 32, 48 or 64 kilobytes.
// - any reset starts at address zero; vectors are 0008h and 0018h.
// - interrupt wake-up with a global enable set loads the vector.
// - interrupt wake-up pushes the program counter onto the stack.
// - wake-up sets cause bits in flag registers, others unchanged.
// - first port bits 6 and 7 exist only in freeing oscillator modes.
// - unimplemented bits read zero; unchanged bits keep their value.
// - priority and first port direction registers reset to ones; wake-up keeps them.
// - flag and enable registers clear on reset; wake-up keeps enables, sets cause flags.
// - latch keeps value on non-power resets, pins read with bits 0-3 and 5 zero; power-on forces zeros.
// - trim resets to zero; fifth direction low three bits reset to one.
`timescale 1ns/10ps
`include "crspc_map.vh"
module crspc_core_reset #(
    parameter FLASH_KB = `CRSPC_FLASH_KB
) (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire        por_reset,
    input  wire        other_reset,
    input  wire        wake_event,
    input  wire        wake_by_irq,
    input  wire        wake_high_prio,
    input  wire        global_high_irq_enable,
    input  wire        global_low_irq_enable,
    input  wire [7:0]  wake_cause_one,
    input  wire [5:0]  wake_cause_two,
    input  wire        osc_frees_pins,
    input  wire        pc_advance,
    input  wire        sw_write_en,
    input  wire [3:0]  sw_write_sel,
    input  wire [7:0]  sw_write_data,
    input  wire [7:0]  pin_levels,
    input  wire [15:0] flash_word,
    input  wire        data_req,
    input  wire [11:0] data_addr_in,
    output reg  [20:0] program_counter,
    output reg  [4:0]  return_stack_pointer,
    output reg  [7:0]  top_of_stack_upper,
    output reg  [7:0]  top_of_stack_high,
    output reg  [7:0]  top_of_stack_low,
    output reg  [7:0]  irq_priority_one,
    output reg  [5:0]  irq_priority_two,
    output reg  [7:0]  irq_enable_one,
    output reg  [5:0]  irq_enable_two,
    output reg  [7:0]  peripheral_flag_one,
    output reg  [5:0]  peripheral_flag_two,
    output reg  [7:0]  oscillator_trim,
    output reg  [7:0]  first_port_direction,
    output reg  [7:0]  first_port_latch,
    output reg  [7:0]  first_port_pins,
    output reg  [7:0]  fifth_port_direction,
    output reg  [11:0] data_addr,
    output reg         data_strobe,
    output wire [15:0] fetch_word,
    output wire        fetch_valid,
    output wire        flash_sel
);
    localparam SEL_PRIO1 = 4'h0;
    localparam SEL_PRIO2 = 4'h1;
    localparam SEL_EN1   = 4'h2;
    localparam SEL_EN2   = 4'h3;
    localparam SEL_FLAG1 = 4'h4;
    localparam SEL_FLAG2 = 4'h5;
    localparam SEL_TRIM  = 4'h6;
    localparam SEL_DIR   = 4'h7;
    localparam SEL_LAT   = 4'h8;
    localparam SEL_DIR5  = 4'h9;

    // only legal flash sizes, else the smallest
    localparam LEGAL_KB  = (FLASH_KB == 16 || FLASH_KB == 32 || FLASH_KB == 48 || FLASH_KB == 64)
                           ? FLASH_KB : `CRSPC_FLASH_KB;

    localparam ST_RUN  = 3'b001;
    localparam ST_WAKE = 3'b010;
    localparam ST_VEC  = 3'b100;

    reg  [2:0]  state;
    reg  [20:0] next_pc;
    reg         fetch_req;
    wire        any_reset = por_reset | other_reset;
    wire        irq_wake  = wake_event & wake_by_irq & (global_high_irq_enable | global_low_irq_enable);
    wire [7:0]  osc_mask  = osc_frees_pins ? 8'hFF : ~`CRSPC_OSC_BITS;
    wire [4:0]  sp_inc    = return_stack_pointer + 5'h01;

    function [7:0] port_mask;
        input [7:0] value;
        input [7:0] mask;
        begin
            port_mask = value & mask;
        end
    endfunction

    crspc_program_space #(
        .FLASH_KB    (LEGAL_KB)
    ) u_space (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .fetch_addr  (program_counter),
        .fetch_req   (fetch_req),
        .flash_word  (flash_word),
        .fetch_word  (fetch_word),
        .fetch_valid (fetch_valid),
        .flash_sel   (flash_sel)
    );

    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            data_addr   <= 12'h000;
            data_strobe <= 1'b0;
        end
        else
        begin
            data_addr   <= data_addr_in;
            data_strobe <= data_req;
        end
    end

    always @*
    begin
        next_pc = program_counter;
        if (pc_advance)
            next_pc = program_counter + 21'h000002;
    end

    always @(posedge clock)
    begin
        if (sys_rst | any_reset)
        begin
            program_counter      <= `CRSPC_RESET_VEC;
            return_stack_pointer <= 5'h00;
            top_of_stack_upper   <= 8'h00;
            top_of_stack_high    <= 8'h00;
            top_of_stack_low     <= 8'h00;
            state                <= ST_RUN;
            fetch_req            <= 1'b0;
        end
        else
        begin
            fetch_req <= 1'b1;
            case (state)
                ST_RUN:
                begin
                    program_counter <= next_pc;
                    if (irq_wake)
                        state <= ST_WAKE;
                end
                ST_WAKE:
                begin
                    return_stack_pointer <= sp_inc;
                    top_of_stack_upper   <= {3'b000, program_counter[20:16]};
                    top_of_stack_high    <= program_counter[15:8];
                    top_of_stack_low     <= program_counter[7:0];
                    state                <= ST_VEC;
                end
                ST_VEC:
                begin
                    program_counter <= wake_high_prio ? `CRSPC_HIGH_VEC : `CRSPC_LOW_VEC;
                    state           <= ST_RUN;
                end
                default:
                    state <= ST_RUN;
            endcase
        end
    end

    always @(posedge clock)
    begin
        if (sys_rst | any_reset)
        begin
            irq_priority_one     <= `CRSPC_PRIO1_RST;
            irq_priority_two     <= `CRSPC_PRIO2_RST;
            first_port_direction <= port_mask(`CRSPC_DIR_RST, osc_mask);
            irq_enable_one       <= `CRSPC_EN1_RST;
            irq_enable_two       <= `CRSPC_EN2_RST;
            peripheral_flag_one  <= `CRSPC_FLAG1_RST;
            peripheral_flag_two  <= `CRSPC_FLAG2_RST;
            oscillator_trim      <= `CRSPC_TRIM_RST;
            fifth_port_direction <= `CRSPC_DIR5_RST;
            if (sys_rst | por_reset)
                first_port_latch <= 8'h00;
        end
        else
        begin
            if (wake_event)
            begin
                peripheral_flag_one <= peripheral_flag_one | wake_cause_one;
                peripheral_flag_two <= peripheral_flag_two | wake_cause_two;
            end
            if (!osc_frees_pins)
            begin
                first_port_direction <= port_mask(first_port_direction, osc_mask);
                first_port_latch     <= port_mask(first_port_latch, osc_mask);
            end
            if (sw_write_en)
            begin
                case (sw_write_sel)
                    SEL_PRIO1: irq_priority_one <= sw_write_data;
                    SEL_PRIO2: irq_priority_two <= sw_write_data[5:0];
                    SEL_EN1:   irq_enable_one   <= sw_write_data;
                    SEL_EN2:   irq_enable_two   <= sw_write_data[5:0];
                    // set wins over clear
                    SEL_FLAG1: peripheral_flag_one <= sw_write_data
                                                    | (wake_event ? wake_cause_one : 8'h00);
                    SEL_FLAG2: peripheral_flag_two <= sw_write_data[5:0]
                                                    | (wake_event ? wake_cause_two : 6'h00);
                    SEL_TRIM:  oscillator_trim  <= sw_write_data & `CRSPC_TRIM_MASK;
                    SEL_DIR:   first_port_direction <= port_mask(sw_write_data, osc_mask);
                    SEL_LAT:   first_port_latch <= port_mask(sw_write_data, osc_mask);
                    SEL_DIR5:  fifth_port_direction <= sw_write_data & `CRSPC_DIR5_MASK;
                    default:   oscillator_trim  <= oscillator_trim;
                endcase
            end
        end
    end

    // pins sampled, forced bits zero on resets
    always @(posedge clock)
    begin
        if (sys_rst | por_reset)
            first_port_pins <= 8'h00;
        else if (other_reset)
            first_port_pins <= port_mask(pin_levels, osc_mask & ~`CRSPC_PINS_ZERO_OTH);
        else
            first_port_pins <= port_mask(pin_levels, osc_mask);
    end
endmodule // crspc_core_reset

// file: src/crspc_map.vh
// constants for the core reset state and program space block
`ifndef CRSPC_MAP_VH
`define CRSPC_MAP_VH
`define CRSPC_PC_W          21
`define CRSPC_SPACE_BYTES   22'h200000
`define CRSPC_RESET_VEC     21'h000000
`define CRSPC_HIGH_VEC      21'h000008
`define CRSPC_LOW_VEC       21'h000018
`define CRSPC_FLASH_KB      16
`define CRSPC_PRIO2_RST     6'h3F
`define CRSPC_PRIO1_RST     8'hFF
`define CRSPC_FLAG2_RST     6'h00
`define CRSPC_FLAG1_RST     8'h00
`define CRSPC_EN2_RST       6'h00
`define CRSPC_EN1_RST       8'h00
`define CRSPC_TRIM_RST      8'h00
`define CRSPC_TRIM_MASK     8'hDF
`define CRSPC_DIR_RST       8'hFF
`define CRSPC_DIR5_RST      8'h07
`define CRSPC_DIR5_MASK     8'hF7
`define CRSPC_PINS_ZERO     8'h2F
`define CRSPC_PINS_ZERO_POR 8'h2F
`define CRSPC_PINS_ZERO_OTH 8'h2F
`define CRSPC_OSC_BITS      8'hC0
`define CRSPC_SP_W          5
`endif

// file: src/crspc_program_space.v
// program space decoder returning zeros above the implemented flash
`timescale 1ns/10ps
`include "crspc_map.vh"
module crspc_program_space #(
    parameter FLASH_KB = `CRSPC_FLASH_KB
) (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire [20:0] fetch_addr,
    input  wire        fetch_req,
    input  wire [15:0] flash_word,
    output reg  [15:0] fetch_word,
    output reg         fetch_valid,
    output reg         flash_sel
);
    localparam integer FLASH_BYTES_INT = FLASH_KB * 1024;
    localparam [21:0]  FLASH_BYTES     = FLASH_BYTES_INT[21:0];
    wire in_flash = ({1'b0, fetch_addr} < FLASH_BYTES);
    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            fetch_word  <= 16'h0000;
            fetch_valid <= 1'b0;
            flash_sel   <= 1'b0;
        end
        else
        begin
            fetch_valid <= fetch_req;
            flash_sel   <= fetch_req & in_flash;
            fetch_word  <= (fetch_req & in_flash) ? flash_word : 16'h0000;
        end
    end
endmodule // crspc_program_space

// file: testbench/crspc_flash_model.sv
// flash program memory model for the core reset bench
`timescale 1ns/10ps
module crspc_flash_model (
    input  logic [20:0] program_counter,
    output logic [15:0] flash_word
);
    // own bus, array aliases so words above flash are nonzero
    assign flash_word = program_counter[16:1] ^ 16'h5A5A;
endmodule // crspc_flash_model

// file: testbench/crspc_core_reset_props.sv
// checker for the core reset block
`timescale 1ns/10ps
module crspc_core_reset_props #(parameter FLASH_KB = 16) (
    input logic        clock,
    input logic        sys_rst,
    input logic        por_reset,
    input logic        other_reset,
    input logic        wake_event,
    input logic        wake_by_irq,
    input logic        wake_high_prio,
    input logic        global_high_irq_enable,
    input logic        global_low_irq_enable,
    input logic [7:0]  wake_cause_one,
    input logic        osc_frees_pins,
    input logic [20:0] program_counter,
    input logic [4:0]  return_stack_pointer,
    input logic [7:0]  irq_priority_one,
    input logic [7:0]  peripheral_flag_one,
    input logic [7:0]  first_port_direction,
    input logic [15:0] fetch_word,
    input logic        fetch_valid
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire irqw = wake_event && wake_by_irq && (global_high_irq_enable || global_low_irq_enable);
    a_reset_start: assert property (por_reset |=> program_counter == 21'h000000)
        else $error("pc not cleared");
    a_prio_ones: assert property ((por_reset || other_reset) |=> irq_priority_one == 8'hFF)
        else $error("priority not set");
    a_port_high_off: assert property (!osc_frees_pins [*2] |-> first_port_direction[7:6] == 2'b00)
        else $error("port bits alive");
    a_vec_high: assert property (irqw && wake_high_prio |-> ##3 program_counter == 21'h000008)
        else $error("bad high vector");
    a_vec_low: assert property (irqw && !wake_high_prio |-> ##3 program_counter == 21'h000018)
        else $error("bad low vector");
    a_stack_push: assert property (irqw |-> ##2 return_stack_pointer == $past(return_stack_pointer, 2) + 5'h01)
        else $error("no push");
    a_cause_set: assert property (wake_event |=> (peripheral_flag_one & $past(wake_cause_one)) == $past(wake_cause_one))
        else $error("cause lost");
    a_zero_above: assert property (fetch_valid && $past(program_counter) >= FLASH_KB * 1024 |-> fetch_word == 16'h0000)
        else $error("nonzero above flash");
    cover property (irqw && wake_high_prio);
    cover property (irqw && !wake_high_prio);
    cover property (fetch_valid && program_counter >= FLASH_KB * 1024);
endmodule // crspc_core_reset_props
bind crspc_core_reset crspc_core_reset_props #(.FLASH_KB(FLASH_KB)) crspc_core_reset_props_i (.*);

// file: testbench/tb_crspc_core_reset.sv
// self-checking bench for the core reset block
`timescale 1ns/10ps
module tb_crspc_core_reset;
    logic clock = 1'b0, sys_rst = 1'b1, por_reset = 1'b0, other_reset = 1'b0, wake_event = 1'b0, wake_by_irq = 1'b0;
    logic wake_high_prio = 1'b0, global_high_irq_enable = 1'b0, global_low_irq_enable = 1'b0, osc_frees_pins = 1'b0;
    logic pc_advance = 1'b0, sw_write_en = 1'b0, data_req = 1'b0;
    logic [3:0] sw_write_sel = 4'h0;
    logic [5:0] wake_cause_two = 6'h00;
    logic [7:0] sw_write_data = 8'h00, wake_cause_one = 8'h00, pin_levels = 8'h00;
    logic [11:0] data_addr_in = 12'h000;
    wire [20:0] program_counter;
    wire [15:0] flash_word, fetch_word;
    wire [11:0] data_addr;
    wire [7:0] top_of_stack_upper, top_of_stack_high, top_of_stack_low, irq_priority_one, irq_enable_one;
    wire [7:0] peripheral_flag_one, oscillator_trim, first_port_direction, first_port_latch, first_port_pins;
    wire [7:0] fifth_port_direction;
    wire [5:0] irq_priority_two, irq_enable_two, peripheral_flag_two;
    wire [4:0] return_stack_pointer;
    wire data_strobe, fetch_valid, flash_sel;
    int fails = 0, checked = 0, cycles = 0;
    crspc_core_reset #(.FLASH_KB(16)) crspc_core_reset_i (.*);
    crspc_flash_model crspc_flash_model_i (.program_counter, .flash_word);
    initial forever #5 clock = ~clock;
    task automatic cmp(input logic [20:0] seen, input logic [20:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] sel, input logic [7:0] data);
        @(posedge clock);
        sw_write_en <= 1'b1;
        sw_write_sel <= sel;
        sw_write_data <= data;
        @(posedge clock);
        sw_write_en <= 1'b0;
        @(posedge clock);
        #1;
    endtask
    task automatic pulse(input logic por);
        @(posedge clock);
        if (por) por_reset <= 1'b1;
        else other_reset <= 1'b1;
        @(posedge clock);
        por_reset <= 1'b0;
        other_reset <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic wake(input logic hp, input logic [7:0] cause);
        @(posedge clock);
        wake_high_prio <= hp;
        wake_cause_one <= cause;
        wake_cause_two <= cause[5:0];
        wake_event <= 1'b1;
        wake_by_irq <= 1'b1;
        @(posedge clock);
        wake_event <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic end_of_test;
        if (fails == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 12000)
        begin
            fails++;
            end_of_test;
        end
    end
    initial
    begin
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        cmp(program_counter, 21'h000000);
        cmp(irq_priority_one, 8'hFF);
        cmp(irq_enable_one, 8'h00);
        cmp(peripheral_flag_one, 8'h00);
        cmp(fifth_port_direction, 8'h07);
        cmp(first_port_direction, 8'h3F);
        cmp(irq_priority_two, 6'h3F);
        cmp(irq_enable_two, 6'h00);
        cmp(peripheral_flag_two, 6'h00);
        cmp(return_stack_pointer, 5'h00);
        cmp(fetch_valid, 1'b1);
        @(posedge clock);
        pin_levels <= 8'hFF;
        data_req <= 1'b1;
        data_addr_in <= 12'hABC;
        wr(4'h6, 8'hFF);
        cmp(oscillator_trim, 8'hDF);
        wr(4'h9, 8'hFF);
        cmp(fifth_port_direction, 8'hF7);
        wr(4'h0, 8'h12);
        cmp(irq_priority_one, 8'h12);
        wr(4'h2, 8'hA5);
        cmp(irq_enable_one, 8'hA5);
        wr(4'h3, 8'hFF);
        cmp(irq_enable_two, 6'h3F);
        wr(4'h7, 8'h55);
        cmp(first_port_direction, 8'h15);
        wr(4'h8, 8'hCA);
        cmp(first_port_latch, 8'h0A);
        cmp(first_port_pins, 8'h3F);
        cmp(data_addr, 12'hABC);
        cmp(data_strobe, 1'b1);
        @(posedge clock);
        osc_frees_pins <= 1'b1;
        wr(4'h8, 8'hCA);
        cmp(first_port_latch, 8'hCA);
        cmp(first_port_pins, 8'hFF);
        pulse(1'b0);
        cmp(irq_priority_one, 8'hFF);
        cmp(first_port_direction, 8'hFF);
        cmp(irq_enable_one, 8'h00);
        cmp(irq_enable_two, 6'h00);
        cmp(oscillator_trim, 8'h00);
        cmp(first_port_latch, 8'hCA);
        @(posedge clock);
        global_high_irq_enable <= 1'b1;
        wake(1'b1, 8'h04);
        cmp(program_counter, 21'h000008);
        cmp(return_stack_pointer, 5'h01);
        cmp(peripheral_flag_one, 8'h04);
        cmp(peripheral_flag_two, 6'h04);
        cmp(irq_priority_one, 8'hFF);
        @(posedge clock);
        global_high_irq_enable <= 1'b0;
        global_low_irq_enable <= 1'b1;
        wake(1'b0, 8'h10);
        cmp(program_counter, 21'h000018);
        cmp(top_of_stack_low, 8'h08);
        cmp(peripheral_flag_one, 8'h14);
        cmp(peripheral_flag_two, 6'h14);
        cmp(fetch_word, 16'h5A56);
        wr(4'h4, 8'h00);
        cmp(peripheral_flag_one, 8'h00);
        @(posedge clock);
        pc_advance <= 1'b1;
        repeat (8200) @(posedge clock);
        pc_advance <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        cmp(program_counter, 21'h004028);
        cmp(fetch_word, 16'h0000);
        cmp(flash_sel, 1'b0);
        wake(1'b1, 8'h01);
        cmp(program_counter, 21'h000008);
        cmp(return_stack_pointer, 5'h03);
        cmp(top_of_stack_upper, 8'h00);
        cmp(top_of_stack_high, 8'h40);
        cmp(top_of_stack_low, 8'h28);
        cmp(peripheral_flag_one, 8'h01);
        pulse(1'b1);
        cmp(first_port_latch, 8'h00);
        cmp(program_counter, 21'h000000);
        cmp(return_stack_pointer, 5'h00);
        end_of_test;
    end
endmodule // tb_crspc_core_reset
